// ===== rtl/apm_modem_ctl.sv
// apm_modem_ctl: modem control, line parameters and sense bytes of one port.
// assumes command bytes, sense requests and read/write activity are on clk.
// Operation
// - sense byte 2 bits 0-3 show live carrier, ring, dsr, cts levels.
// - carrier falling during read sets bit 4, ends read, unit check.
// - ring trailing edge sets bit 5; attention if ring enabled.
// - any dsr change sets bit 6; ends read or attention if dtr.
// - cts falling sets bit 7; ends read full duplex or write half duplex.
// - mode byte: half, ring, defined, diag, drivers off, zero, rts, dtr.
// - diagnostic mode loops transmit data to receive, not modem lines.
// - break bit set holds serial output at logic zero.
// - forced parity sends one for odd, zero for even.
// - parity enabled generates and checks parity; set select means even.
// - stop selector gives two stop bits, 1.5 for five bits, else one.
// - two-bit length field: 00 five up to 11 eight bits.
// - four-bit baud code, 1110/1111 external clocks, zero until defined.
// - wake-up inhibit bit blocks wake-up character detection.
// - define-special stores termination bytes; only define-parameters or reset clears.
// - dtr set or cleared by command, cleared by controller clear or reset.
// - rts cleared by command, clears, reset, and half-duplex write end.
// - rts set by command and at half-duplex write start.
// - define-parameters sets dtr and rts from ring and duplex settings.
// - set-break clamps output until reset-break or define-parameters.
// - last two sense bytes give firmware id and revision.
`timescale 1ns/1ps
`default_nettype none
module apm_modem_ctl (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // command bytes and clears
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_byte,
    input  wire logic       dev_clear,
    input  wire logic       ctl_clear,
    // sense access
    input  wire logic       sense_rd,
    input  wire logic [2:0] sense_idx,
    output logic      [7:0] sense_data,
    // operation activity and results
    input  wire logic       read_active,
    input  wire logic       write_active,
    input  wire logic       write_start,
    input  wire logic       write_done,
    output logic            term_read,
    output logic            term_write,
    output logic            unit_check,
    output logic            attention,
    // modem pins
    input  wire logic       carrier_detect_in,
    input  wire logic       ring_in,
    input  wire logic       dsr_in,
    input  wire logic       cts_in,
    output logic            dtr_out,
    output logic            rts_out,
    output logic            drv_en_out,
    // serial data
    input  wire logic       tx_serial_in,
    output logic            txd_out,
    input  wire logic       rxd_in,
    output logic            rx_serial_out,
    // character path
    input  wire logic [7:0] tx_char,
    output logic            tx_par_bit,
    input  wire logic       rx_char_valid,
    input  wire logic [7:0] rx_char,
    input  wire logic       rx_par,
    output logic            rx_par_err,
    output logic            special_hit,
    output logic            wake_hit,
    // line format
    output logic            par_en_out,
    output logic      [1:0] char_len_out,
    output logic      [2:0] stop_halves,
    output logic      [3:0] baud_code_out,
    output logic            ext_clk_16x,
    output logic            ext_clk_1x
);
    import apm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pins_s;
    logic       cd_s, ri_s, dsr_s, cts_s, rxd_s;
    logic       cd_q, ri_q, dsr_q, cts_q;

    apm_sync #(.W(5)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({carrier_detect_in, ring_in, dsr_in, cts_in, rxd_in}),
        .dout   (pins_s)
    );
    assign {cd_s, ri_s, dsr_s, cts_s, rxd_s} = pins_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {cd_q, ri_q, dsr_q, cts_q} <= 4'h0;
        end else begin
            {cd_q, ri_q, dsr_q, cts_q} <= {cd_s, ri_s, dsr_s, cts_s};
        end
    end

    // edges count only once both stages hold real pin levels, else a false edge follows reset
    logic [2:0] arm_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arm_reg <= 3'h0;
        end else begin
            arm_reg <= {arm_reg[1:0], 1'b1};
        end
    end
    wire armed = arm_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // state registers
    apm_state_t st_reg;
    logic [7:0] p1_reg, p2_reg, wake_reg, p1_hold, p2_hold;
    logic       defined_reg, break_reg, drv_dis_reg;
    logic       dtr_reg, rts_reg;
    logic       d_cd_reg, d_ri_reg, d_dsr_reg, d_cts_reg;
    logic [7:0] spec_mem [SPEC_DEPTH];
    logic [SPEC_DEPTH-1:0] spec_vld_reg;

    wire half_w = p1_reg[P1_HALF];
    wire ring_w = p1_reg[P1_RING];
    wire diag_w = p2_reg[P2_DIAG];

    ////////////////////////////////////////////////////////////////////////
    // command decode
    wire in_idle   = (st_reg == ST_IDLE);
    wire code_v    = cmd_valid && in_idle;
    wire c_dtr_clr = code_v && (cmd_byte == CMD_DTR_CLR);
    wire c_dtr_set = code_v && (cmd_byte == CMD_DTR_SET);
    wire c_rts_clr = code_v && (cmd_byte == CMD_RTS_CLR);
    wire c_rts_set = code_v && (cmd_byte == CMD_RTS_SET);
    wire c_brk_clr = code_v && (cmd_byte == CMD_BRK_CLR);
    wire c_brk_set = code_v && (cmd_byte == CMD_BRK_SET);
    wire c_drv_en  = code_v && (cmd_byte == CMD_DRV_EN);
    wire c_drv_dis = code_v && (cmd_byte == CMD_DRV_DIS);
    wire spec_wr   = cmd_valid && (st_reg == ST_SPEC);
    wire def_done  = cmd_valid && (st_reg == ST_P3);

    // parameters take effect together when the third byte lands
    wire n_half = p1_hold[P1_HALF];
    wire n_ring = p1_hold[P1_RING];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_IDLE;
        end else if (cmd_valid) begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (cmd_byte == CMD_SPECIAL) begin
                        st_reg <= ST_SPEC;
                    end else if (cmd_byte == CMD_DEFINE) begin
                        st_reg <= ST_P1;
                    end
                end
                ST_SPEC: st_reg <= ST_IDLE;
                ST_P1:   st_reg <= ST_P2;
                ST_P2:   st_reg <= ST_P3;
                ST_P3:   st_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_hold <= P1_RESET;
            p2_hold <= P2_RESET;
        end else if (cmd_valid && st_reg == ST_P1) begin
            p1_hold <= cmd_byte;
        end else if (cmd_valid && st_reg == ST_P2) begin
            p2_hold <= cmd_byte;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_reg      <= P1_RESET;
            p2_reg      <= P2_RESET;
            wake_reg    <= WAKE_RESET;
            defined_reg <= 1'b0;
        end else if (def_done) begin
            p1_reg      <= p1_hold;
            p2_reg      <= p2_hold;
            wake_reg    <= cmd_byte;
            defined_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            break_reg <= 1'b0;
        end else if (c_brk_clr || def_done) begin
            break_reg <= 1'b0;
        end else if (c_brk_set) begin
            break_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv_dis_reg <= 1'b0;
        end else if (c_drv_dis) begin
            drv_dis_reg <= 1'b1;
        end else if (c_drv_en) begin
            drv_dis_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // special termination characters
    logic [SPEC_DEPTH-1:0] spec_free;
    logic                  spec_below;
    always_comb begin
        spec_free  = '0;
        spec_below = 1'b1;
        for (int i = 0; i < SPEC_DEPTH; i++) begin
            spec_free[i] = !spec_vld_reg[i] && spec_below;
            spec_below   = spec_below && spec_vld_reg[i];
        end
    end

    // store is full at SPEC_DEPTH; further defines are dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spec_vld_reg <= '0;
        end else if (def_done) begin
            spec_vld_reg <= '0;
        end else if (spec_wr) begin
            spec_vld_reg <= spec_vld_reg | spec_free;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < SPEC_DEPTH; i++) begin
            if (spec_wr && spec_free[i]) begin
                spec_mem[i] <= cmd_byte;
            end
        end
    end

    logic spec_match;
    always_comb begin
        spec_match = 1'b0;
        for (int i = 0; i < SPEC_DEPTH; i++) begin
            spec_match = spec_match || (spec_vld_reg[i] && spec_mem[i] == rx_char);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // terminal-ready and request-to-send
    // ring is never a cause here: answering is left to software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dtr_reg <= 1'b0;
        end else if (ctl_clear || c_dtr_clr) begin
            dtr_reg <= 1'b0;
        end else if (c_dtr_set) begin
            dtr_reg <= 1'b1;
        end else if (def_done) begin
            if (n_ring) begin
                dtr_reg <= 1'b0;
            end else if (!n_half) begin
                dtr_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rts_reg <= 1'b0;
        end else if (dev_clear || ctl_clear || c_rts_clr) begin
            rts_reg <= 1'b0;
        end else if (c_rts_set) begin
            rts_reg <= 1'b1;
        end else if (def_done) begin
            rts_reg <= !n_ring && !n_half;
        end else if (half_w && write_done) begin
            rts_reg <= 1'b0;
        end else if (half_w && write_start) begin
            rts_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem transitions
    wire ev_cd   = armed && cd_q && !cd_s && read_active;
    wire ev_ri   = armed && ri_q && !ri_s;
    wire ev_dsr  = armed && (dsr_q != dsr_s);
    wire ev_cts  = armed && cts_q && !cts_s;
    wire cts_rd  = ev_cts && !half_w && read_active;
    wire cts_wr  = ev_cts && half_w && write_active;
    wire end_rd  = ev_cd || (ev_dsr && read_active) || cts_rd;
    wire attn_w  = (ev_ri && ring_w) || (ev_dsr && !read_active && dtr_reg);
    wire d_clear = sense_rd && (sense_idx == SNS_MODEM);

    // a transition in the clearing cycle survives: set beats clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {d_cd_reg, d_ri_reg, d_dsr_reg, d_cts_reg} <= 4'h0;
        end else begin
            d_cd_reg  <= ev_cd  || (d_cd_reg  && !d_clear);
            d_ri_reg  <= ev_ri  || (d_ri_reg  && !d_clear);
            d_dsr_reg <= ev_dsr || (d_dsr_reg && !d_clear);
            d_cts_reg <= ev_cts || (d_cts_reg && !d_clear);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            term_read  <= 1'b0;
            term_write <= 1'b0;
            unit_check <= 1'b0;
            attention  <= 1'b0;
        end else begin
            term_read  <= end_rd;
            term_write <= cts_wr;
            unit_check <= end_rd || cts_wr;
            attention  <= attn_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line format and character checks
    wire [1:0] len_w  = p1_reg[P1_LEN_LO +: 2];
    wire [7:0] mask_w = 8'hFF >> (2'd3 - len_w);
    wire       odd_w  = !p1_reg[P1_EVEN];
    wire       tx_par = p1_reg[P1_FORCE] ? odd_w
                      : (^(tx_char & mask_w)) ^ odd_w;
    wire       rx_exp = p1_reg[P1_FORCE] ? odd_w
                      : (^(rx_char & mask_w)) ^ odd_w;
    wire [3:0] baud_w = defined_reg ? p2_reg[P2_BAUD_LO +: 4] : 4'h0;

    assign par_en_out    = p1_reg[P1_PAREN];
    assign char_len_out  = len_w;
    assign stop_halves   = !p1_reg[P1_STOP2] ? STOP_ONE
                         : (len_w == 2'b00) ? STOP_ONE_HALF : STOP_TWO;
    assign baud_code_out = baud_w;
    assign ext_clk_16x   = baud_w == BAUD_EXT16;
    assign ext_clk_1x    = baud_w == BAUD_EXT1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_par_bit  <= 1'b0;
            rx_par_err  <= 1'b0;
            special_hit <= 1'b0;
            wake_hit    <= 1'b0;
        end else begin
            tx_par_bit  <= tx_par;
            rx_par_err  <= rx_char_valid && par_en_out && (rx_par != rx_exp);
            special_hit <= rx_char_valid && spec_match;
            wake_hit    <= rx_char_valid && !p2_reg[P2_WINH]
                           && !read_active && ((rx_char & mask_w) == (wake_reg & mask_w));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial data, loop-back, pins
    // loop covers data only; modem inputs always come from the pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txd_out       <= 1'b1;
            rx_serial_out <= 1'b1;
        end else begin
            txd_out       <= !break_reg && tx_serial_in;
            rx_serial_out <= diag_w ? tx_serial_in : rxd_s;
        end
    end

    assign dtr_out    = dtr_reg;
    assign rts_out    = rts_reg;
    assign drv_en_out = !drv_dis_reg;

    ////////////////////////////////////////////////////////////////////////
    // sense bytes
    wire [7:0] sb_modem = {cd_s, ri_s, dsr_s, cts_s,
                           d_cd_reg, d_ri_reg, d_dsr_reg, d_cts_reg};
    wire [7:0] sb_mode  = {half_w, ring_w, defined_reg, diag_w,
                           drv_dis_reg, 1'b0, rts_reg, dtr_reg};
    wire [7:0] sb_line  = {1'b0, break_reg, p1_reg[5:0]};
    wire [7:0] sb_baud  = {2'b00, p2_reg[P2_WINH], 1'b0, baud_w};
    wire [7:0] sb_mux   = (sense_idx == SNS_MODEM) ? sb_modem
                        : (sense_idx == SNS_MODE)  ? sb_mode
                        : (sense_idx == SNS_LINE)  ? sb_line
                        : (sense_idx == SNS_BAUD)  ? sb_baud
                        : (sense_idx == SNS_FWID)  ? FW_ID
                        : (sense_idx == SNS_REV)   ? FW_REV
                        : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sense_data <= 8'h00;
        end else begin
            sense_data <= sb_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_cd_drop;
        $fell(cd_s) && read_active;
    endsequence
    sequence s_end_read;
        term_read && unit_check;
    endsequence

    cd_drop_ends_a: assert property (@(posedge clk) disable iff (!resetn)
        s_cd_drop |=> s_end_read ##0 d_cd_reg)
        else $error("carrier loss did not end read");
    ring_trail_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(ri_s) |=> !d_ri_reg || $past(d_ri_reg))
        else $error("ring leading edge set ring bit");
    ring_attn_a: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(ri_s) && ring_w) |=> attention)
        else $error("ring without attention");
    dsr_attn_a: assert property (@(posedge clk) disable iff (!resetn)
        (armed && $changed(dsr_s) && !read_active && dtr_reg) |=> attention && d_dsr_reg)
        else $error("dsr change without attention");
    cts_write_a: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(cts_s) && half_w && write_active) |=> term_write && unit_check && !term_read)
        else $error("cts drop did not end write");
    brk_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        break_reg |=> !txd_out)
        else $error("break not held at zero");
    brk_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
        (c_brk_set || (break_reg && !c_brk_clr && !def_done)) |=> break_reg)
        else $error("set break did not clamp");
    dtr_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        ctl_clear |=> !dtr_out && !rts_out)
        else $error("controller clear left dtr or rts");
    rts_half_a: assert property (@(posedge clk) disable iff (!resetn)
        (half_w && write_start && !write_done && !dev_clear && !ctl_clear
         && !c_rts_clr && !def_done) |=> rts_out)
        else $error("half duplex write did not raise rts");
    def_ring_a: assert property (@(posedge clk) disable iff (!resetn)
        (def_done && n_ring && !c_dtr_set) |=> !dtr_out && !rts_out && sb_mode[6])
        else $error("ring define left outputs set");
    baud_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        !defined_reg |-> baud_code_out == 4'h0)
        else $error("baud code shown before define");
endmodule
`default_nettype wire

// ===== rtl/apm_pkg.sv
// apm_pkg: constants shared by the port modem-control block.
// assumes bit 0 of every byte is its most significant bit, index 7.
package apm_pkg;
    // control codes
    localparam logic [7:0] CMD_NOP       = 8'h03;
    localparam logic [7:0] CMD_SPECIAL   = 8'h0B;
    localparam logic [7:0] CMD_DTR_CLR   = 8'h13;
    localparam logic [7:0] CMD_DTR_SET   = 8'h17;
    localparam logic [7:0] CMD_RTS_CLR   = 8'h1B;
    localparam logic [7:0] CMD_RTS_SET   = 8'h1F;
    localparam logic [7:0] CMD_BRK_CLR   = 8'h33;
    localparam logic [7:0] CMD_BRK_SET   = 8'h37;
    localparam logic [7:0] CMD_DRV_EN    = 8'h4B;
    localparam logic [7:0] CMD_DRV_DIS   = 8'h4F;
    localparam logic [7:0] CMD_DEFINE    = 8'hFF;
    // sense byte indices
    localparam logic [2:0] SNS_MODEM     = 3'h2;
    localparam logic [2:0] SNS_MODE      = 3'h3;
    localparam logic [2:0] SNS_LINE      = 3'h4;
    localparam logic [2:0] SNS_BAUD      = 3'h5;
    localparam logic [2:0] SNS_FWID      = 3'h6;
    localparam logic [2:0] SNS_REV       = 3'h7;
    // define-parameters byte 1 (bit 0 = index 7)
    localparam int P1_HALF   = 7;
    localparam int P1_RING   = 6;
    localparam int P1_FORCE  = 5;
    localparam int P1_EVEN   = 4;
    localparam int P1_PAREN  = 3;
    localparam int P1_STOP2  = 2;
    localparam int P1_LEN_LO = 0;
    // define-parameters byte 2
    localparam int P2_WINH   = 5;
    localparam int P2_DIAG   = 4;
    localparam int P2_BAUD_LO = 0;
    // baud codes selecting external clocks
    localparam logic [3:0] BAUD_EXT16    = 4'hE;
    localparam logic [3:0] BAUD_EXT1     = 4'hF;
    // reset values
    localparam logic [7:0] P1_RESET      = 8'h00;
    localparam logic [7:0] P2_RESET      = 8'h00;
    localparam logic [7:0] WAKE_RESET    = 8'h00;
    // special character store depth
    localparam int SPEC_DEPTH            = 4;
    // firmware id and revision: values arbitrary
    localparam logic [7:0] FW_ID         = 8'h5A;
    localparam logic [7:0] FW_REV        = 8'h01;
    // stop length in half bit times
    localparam logic [2:0] STOP_ONE      = 3'h2;
    localparam logic [2:0] STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_TWO      = 3'h4;
    // command parser states
    typedef enum logic [2:0] {
        ST_IDLE, ST_SPEC, ST_P1, ST_P2, ST_P3
    } apm_state_t;
endpackage

// ===== rtl/apm_sync.sv
// apm_sync: two-flop synchroniser for a group of level inputs.
// assumes inputs are asynchronous levels; first stage read only by second.
`timescale 1ns/1ps
`default_nettype none
module apm_sync #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== verif/apm_modem_model.sv
// apm_modem_model: modem seen at the port's modem pins.
// assumes the bench calls its tasks 2 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module apm_modem_model (
    // modem lines
    output logic cd,
    output logic ri,
    output logic dsr,
    output logic cts,
    output logic rxd
);
    initial begin
        {cd, ri, dsr, cts, rxd} = 5'h17;
    end
    task automatic drop_cts();
        cts = 1'b0;
    endtask
    task automatic set_ring(input logic v);
        ri = v;
    endtask
    task automatic set_dsr(input logic v);
        dsr = v;
    endtask
endmodule
`default_nettype wire

// ===== verif/apm_modem_ctl_bench.sv
// apm_modem_ctl_bench: directed scenarios for the modem-control block.
// assumes a 40 MHz clock; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module apm_modem_ctl_bench;
    import apm_pkg::*;
    logic clk, resetn, cmd_valid, dev_clear, ctl_clear, sense_rd, read_active;
    logic write_active, write_start, write_done, tx_serial_in, rx_char_valid, rx_par;
    logic cd, ri, dsr, cts, rxd, term_read, unit_check, dtr_out, rts_out, txd_out;
    logic term_write, attention, drv_en_out, rx_serial_out, tx_par_bit, rx_par_err;
    logic special_hit, wake_hit, par_en_out, ext_clk_16x, ext_clk_1x;
    logic [2:0] stop_halves;
    logic [7:0] cmd_byte, sense_data, tx_char, rx_char;
    logic [2:0] sense_idx;
    logic [1:0] char_len_out;
    logic [3:0] baud_code_out;
    int n_mismatch = 0;
    int samples_checked = 0;
    apm_modem_model m (.cd(cd), .ri(ri), .dsr(dsr), .cts(cts), .rxd(rxd));
    apm_modem_ctl dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .dev_clear(dev_clear), .ctl_clear(ctl_clear),
        .sense_rd(sense_rd), .sense_idx(sense_idx), .sense_data(sense_data),
        .read_active(read_active), .write_active(write_active),
        .write_start(write_start), .write_done(write_done), .term_read(term_read),
        .term_write(term_write), .unit_check(unit_check), .attention(attention),
        .carrier_detect_in(cd), .ring_in(ri), .dsr_in(dsr), .cts_in(cts),
        .dtr_out(dtr_out), .rts_out(rts_out), .drv_en_out(drv_en_out),
        .tx_serial_in(tx_serial_in), .txd_out(txd_out), .rxd_in(rxd),
        .rx_serial_out(rx_serial_out), .tx_char(tx_char), .tx_par_bit(tx_par_bit),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_par(rx_par),
        .rx_par_err(rx_par_err), .special_hit(special_hit), .wake_hit(wake_hit),
        .par_en_out(par_en_out), .char_len_out(char_len_out), .stop_halves(stop_halves),
        .baud_code_out(baud_code_out), .ext_clk_16x(ext_clk_16x), .ext_clk_1x(ext_clk_1x));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // one idle cycle after each byte keeps every drive a single assignment
    task automatic cmd(input logic [7:0] b);
        cmd_valid = 1'b1;
        cmd_byte = b;
        tick(1);
        cmd_valid = 1'b0;
        tick(1);
    endtask
    task automatic sense(input logic [2:0] i, input logic [7:0] exp);
        sense_idx = i;
        tick(1);
        chk(sense_data, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        sense(SNS_FWID, FW_ID);
        sense(SNS_REV, FW_REV);
        sense(SNS_BAUD, 8'h00);
        chk(dtr_out, 8'h00);
    endtask
    task automatic t_define();
        cmd(CMD_DEFINE);
        cmd(8'h1B);
        cmd(8'h2B);
        cmd(8'h00);
        chk(dtr_out, 8'h01);
        chk(rts_out, 8'h01);
        chk(char_len_out, 8'h03);
        chk(baud_code_out, 8'h0B);
        sense(SNS_MODE, 8'h23);
        sense(SNS_LINE, 8'h1B);
        sense(SNS_BAUD, 8'h2B);
    endtask
    task automatic t_fmt();
        chk(stop_halves, STOP_ONE);
        chk(par_en_out, 8'h01);
        tx_char = 8'h01;
        tick(1);
        chk(tx_par_bit, 8'h01);
        cmd(CMD_SPECIAL);
        cmd(8'h2A);
        rx_char = 8'h00;
        rx_par = 1'b1;
        rx_char_valid = 1'b1;
        tick(1);
        chk({rx_par_err, special_hit, wake_hit}, 8'h04);
        rx_char = 8'h2A;
        tick(1);
        rx_char_valid = 1'b0;
        chk({rx_par_err, special_hit, wake_hit}, 8'h02);
    endtask
    task automatic t_ring();
        cmd(CMD_DTR_SET);
        cmd(CMD_RTS_SET);
        cmd(CMD_DEFINE);
        cmd(8'h6C);
        cmd(8'h1E);
        cmd(8'h0A);
        chk({dtr_out, rts_out}, 8'h00);
        chk({tx_par_bit, ext_clk_16x}, 8'h03);
        chk(stop_halves, STOP_ONE_HALF);
        tx_serial_in = 1'b0;
        rx_char_valid = 1'b1;
        tick(1);
        rx_char_valid = 1'b0;
        tx_serial_in = 1'b1;
        chk({rx_serial_out, special_hit, wake_hit}, 8'h01);
        m.set_ring(1'b1);
        tick(4);
        m.set_ring(1'b0);
        tick(3);
        chk({attention, dtr_out}, 8'h02);
        cmd(CMD_DTR_SET);
        m.set_dsr(1'b0);
        tick(3);
        chk({attention, dtr_out}, 8'h03);
        m.set_dsr(1'b1);
        tick(4);
    endtask
    task automatic t_half();
        cmd(CMD_DEFINE);
        cmd(8'h80);
        cmd(8'h00);
        cmd(8'h00);
        chk({dtr_out, rts_out}, 8'h02);
        write_start = 1'b1;
        tick(1);
        write_start = 1'b0;
        chk(rts_out, 8'h01);
        write_done = 1'b1;
        tick(1);
        write_done = 1'b0;
        chk(rts_out, 8'h00);
    endtask
    task automatic t_ctl();
        cmd(CMD_BRK_SET);
        tick(1);
        chk(txd_out, 8'h00);
        sense(SNS_LINE, 8'h5B);
        cmd(CMD_BRK_CLR);
        tick(1);
        chk(txd_out, 8'h01);
        cmd(CMD_DTR_CLR);
        cmd(CMD_RTS_CLR);
        sense(SNS_MODE, 8'h20);
        cmd(CMD_DRV_DIS);
        sense(SNS_MODE, 8'h28);
        chk(drv_en_out, 8'h00);
        cmd(CMD_DRV_EN);
        cmd(CMD_RTS_SET);
        chk(rts_out, 8'h01);
        ctl_clear = 1'b1;
        tick(1);
        ctl_clear = 1'b0;
        tick(1);
        chk(rts_out, 8'h00);
    endtask
    task automatic t_event();
        int k;
        sense_idx = SNS_MODEM;
        sense_rd = 1'b1;
        tick(1);
        sense_rd = 1'b0;
        tick(1);
        chk(sense_data, 8'hB0);
        read_active = 1'b1;
        m.drop_cts();
        for (k = 0; k < 8 && term_read !== 1'b1; k++) tick(1);
        chk({term_read, unit_check}, 8'h03);
        if (k == 8) begin
            n_mismatch++;
            end_of_test();
        end
        tick(2);
        chk(sense_data, 8'hA1);
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {resetn, cmd_valid, dev_clear, ctl_clear, sense_rd, read_active} = '0;
        {write_active, write_start, write_done, rx_char_valid, rx_par} = '0;
        {cmd_byte, tx_char, rx_char, sense_idx} = '0;
        tx_serial_in = 1'b1;
        tick(3);
        resetn = 1'b1;
        t_reset();
        t_define();
        t_fmt();
        t_ctl();
        t_ring();
        t_event();
        t_half();
        cmd(CMD_RTS_SET);
        resetn = 1'b0;
        tick(1);
        resetn = 1'b1;
        chk({dtr_out, rts_out}, 8'h00);
        tick(3);
        sense(SNS_MODEM, 8'hA0);
        end_of_test();
    end
endmodule
`default_nettype wire
